/* core/fpt_timer.sv */
// Fast PWM timer channel unit with APB register access.
// Assumes an APB master on pclk; pin drives a load via port direction.
//
// Overview of operation
// R1: Each instance is one independent 16-bit timer usable as PWM source.
// R2: Waveform mode and output mode together decide counter and pin action.
// R3: Active compare values are compared with the counter every tick.
// R4: Compare matches drive a PWM or toggling waveform onto the pin.
// R5: Two-bit output mode fields per channel; value 2 is non-inverting PWM.
// R6: Waveform mode bits 1:0 in control A, bit 2 in control B.
// R7: Fast PWM 8-bit mode fixes top at 0xFF, 256 ticks per period.
// R8: Three-bit clock select in control B; value 5 divides by 1024.
// R9: PWM frequency is clock over prescale times top plus one.
// R10: Channel A match sets interrupt when its mask bit is enabled.
// R11: Channel A compare value sets the duty cycle on its pin.
// R12: Software must set pin direction to output to see the waveform.
// R13: Counter counts zero to top and wraps; output sets at zero.
// R14: Compare writes go to buffer; active value loads at top.
//
// Register map, byte offsets, one word each, data in the low bits:
// 0x00 control A: [7:6] mode A, [5:4] mode B, [1:0] waveform mode low
// 0x04 control B: [3] waveform mode bit 2, [2:0] clock select
// 0x08 interrupt mask, same layout as status
// 0x0C compare A buffer, 0x10 compare B buffer
// 0x14 counter, read and write
// 0x18 status: [0] overflow, [1] match A, [2] match B; read only
// 0x1C status clear, write one to clear; write only
// 0x20 pin direction: [0] channel A, [1] channel B
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
module fpt_timer
#(
	parameter int WIDTH = 16
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             channel_a_output_pin,
	output logic             channel_a_output_oe_n,
	output logic             channel_b_output_pin,
	output logic             channel_b_output_oe_n,
	output logic             irq
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]                    timer_control_a_ff;
	logic [7:0]                    timer_control_b_ff;
	logic [fpt_pkg::IRQ_WIDTH-1:0] timer_irq_mask_ff;
	logic [fpt_pkg::IRQ_WIDTH-1:0] irq_status_ff;
	logic [1:0]                    pwm_pin_direction_ff;
	logic [WIDTH-1:0]              count_ff;
	logic [31:0]                   prdata_ff;
	logic                          pin_a_ff;
	logic                          pin_b_ff;

	logic [WIDTH-1:0]              nxt_count;
	logic [fpt_pkg::IRQ_WIDTH-1:0] nxt_status;
	logic [31:0]                   nxt_rdata;
	logic [7:0]                    nxt_timer_control_a;
	logic [7:0]                    nxt_timer_control_b;
	logic [fpt_pkg::IRQ_WIDTH-1:0] nxt_timer_irq_mask;
	logic [1:0]                    nxt_pwm_pin_direction;
	logic [WIDTH-1:0]              nxt_count_load;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire access   = psel && penable;
	// Read word is fetched in setup so it stands for the access edge
	wire setup    = psel && !penable;
	wire wr_en    = access && pwrite;
	wire rd_en    = setup && !pwrite;
	wire hit_ca   = (paddr == fpt_pkg::ADDR_CTRL_A);
	wire hit_cb   = (paddr == fpt_pkg::ADDR_CTRL_B);
	wire hit_msk  = (paddr == fpt_pkg::ADDR_IRQ_MASK);
	wire hit_cmpa = (paddr == fpt_pkg::ADDR_CMP_A);
	wire hit_cmpb = (paddr == fpt_pkg::ADDR_CMP_B);
	wire hit_cnt  = (paddr == fpt_pkg::ADDR_COUNT);
	wire hit_st   = (paddr == fpt_pkg::ADDR_IRQ_STATUS);
	wire hit_clr  = (paddr == fpt_pkg::ADDR_IRQ_CLEAR);
	wire hit_dir  = (paddr == fpt_pkg::ADDR_PIN_DIR);
	wire mapped   = hit_ca || hit_cb || hit_msk || hit_cmpa || hit_cmpb ||
		hit_cnt || hit_st || hit_clr || hit_dir;

	// ----------------------------------------------------------------
	// Write strobes, one per writable register
	// ----------------------------------------------------------------
	wire wr_ca    = wr_en && hit_ca;
	wire wr_cb    = wr_en && hit_cb;
	wire wr_msk   = wr_en && hit_msk;
	wire wr_cmpa  = wr_en && hit_cmpa;
	wire wr_cmpb  = wr_en && hit_cmpb;
	wire wr_cnt   = wr_en && hit_cnt;
	wire wr_clr   = wr_en && hit_clr;
	wire wr_dir   = wr_en && hit_dir;

	// ----------------------------------------------------------------
	// Bus response
	// ----------------------------------------------------------------
	assign pready  = 1'b1;
	// Status is read only and clear is write only
	assign pslverr = access && (!mapped || (pwrite && hit_st) ||
		(!pwrite && hit_clr));
	assign prdata  = prdata_ff;

	// ----------------------------------------------------------------
	// Mode fields
	// ----------------------------------------------------------------
	wire [1:0] channel_a_output_mode =
		timer_control_a_ff[fpt_pkg::CTRL_A_COMA_LSB +: 2]; // see R5
	wire [1:0] channel_b_output_mode =
		timer_control_a_ff[fpt_pkg::CTRL_A_COMB_LSB +: 2]; // see R5
	wire [2:0] waveform_mode = {
		timer_control_b_ff[fpt_pkg::CTRL_B_WGM2_BIT],
		timer_control_a_ff[fpt_pkg::CTRL_A_WGM_LSB +: 2]}; // see R6
	wire [2:0] clk_sel = timer_control_b_ff[fpt_pkg::CTRL_B_CS_LSB +: 3];
	wire       pwm_mode = (waveform_mode == fpt_pkg::WGM_FAST_PWM8); // see R2

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	logic             tick;
	logic [WIDTH-1:0] top;
	logic             at_top;

	// ----------------------------------------------------------------
	// Prescaler: one tick per counter clock
	// ----------------------------------------------------------------
	fpt_prescaler u_prescaler
	(
		.pclk    (pclk),
		.presetn (presetn),
		.sel     (clk_sel),
		.tick    (tick)
	);

	// Other waveform modes run normal up-count over the full range
	assign top    = pwm_mode ? fpt_pkg::TOP_PWM8[WIDTH-1:0] :
		fpt_pkg::TOP_FULL[WIDTH-1:0]; // see R7
	assign at_top = (count_ff == top);
	// Period = prescale * (top + 1) pclk cycles, which gives the frequency
	assign nxt_count = at_top ? '0 : count_ff + 1'b1; // see R9, see R13

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] buf_a;
	logic [WIDTH-1:0] buf_b;
	logic             match_a;
	logic             match_b;
	logic             wave_a;
	logic             wave_b;

	fpt_channel #(.WIDTH(WIDTH)) u_chan_a
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.wr       (wr_cmpa),
		.wdata    (pwdata[WIDTH-1:0]),
		.tick     (tick),
		.at_top   (at_top),
		.pwm_mode (pwm_mode),
		.mode     (channel_a_output_mode),
		.count    (count_ff),
		.buf_val  (buf_a),
		.match    (match_a),
		.wave     (wave_a)
	);

	fpt_channel #(.WIDTH(WIDTH)) u_chan_b
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.wr       (wr_cmpb),
		.wdata    (pwdata[WIDTH-1:0]),
		.tick     (tick),
		.at_top   (at_top),
		.pwm_mode (pwm_mode),
		.mode     (channel_b_output_mode),
		.count    (count_ff),
		.buf_val  (buf_b),
		.match    (match_b),
		.wave     (wave_b)
	);

	// ----------------------------------------------------------------
	// Interrupt status: set wins over a clear in the same cycle
	// ----------------------------------------------------------------
	wire                          ovf_event = tick && at_top;
	wire [fpt_pkg::IRQ_WIDTH-1:0] events = {match_b, match_a,
		ovf_event}; // see R10
	wire [fpt_pkg::IRQ_WIDTH-1:0] clr_bits = wr_clr ?
		pwdata[fpt_pkg::IRQ_WIDTH-1:0] : '0;

	assign nxt_status = (irq_status_ff & ~clr_bits) | events;

	// ----------------------------------------------------------------
	// Interrupt output: level, high while an enabled bit is set
	// ----------------------------------------------------------------
	assign irq        = |(irq_status_ff & timer_irq_mask_ff); // see R10

	// ----------------------------------------------------------------
	// Read words, zero extended to the bus width
	// ----------------------------------------------------------------
	wire [31:0] rd_ctrl_a = 32'(timer_control_a_ff);
	wire [31:0] rd_ctrl_b = 32'(timer_control_b_ff);
	wire [31:0] rd_mask   = 32'(timer_irq_mask_ff);
	wire [31:0] rd_cmp_a  = 32'(buf_a);
	wire [31:0] rd_cmp_b  = 32'(buf_b);
	wire [31:0] rd_count  = 32'(count_ff);
	wire [31:0] rd_status = 32'(irq_status_ff);
	wire [31:0] rd_dir    = 32'(pwm_pin_direction_ff);

	// ----------------------------------------------------------------
	// Read select: fetched in setup, so it stands at the access edge
	// ----------------------------------------------------------------
	// Unmapped addresses and the write-only clear read as zero
	assign nxt_rdata =
		!rd_en   ? fpt_pkg::RESET_VALUE :
		hit_ca   ? rd_ctrl_a :
		hit_cb   ? rd_ctrl_b :
		hit_msk  ? rd_mask :
		hit_cmpa ? rd_cmp_a :
		hit_cmpb ? rd_cmp_b :
		hit_cnt  ? rd_count :
		hit_st   ? rd_status :
		hit_dir  ? rd_dir :
		fpt_pkg::RESET_VALUE;

	// ----------------------------------------------------------------
	// Register updates
	// ----------------------------------------------------------------
	assign nxt_timer_control_a = wr_ca ? pwdata[7:0] :
		timer_control_a_ff; // see R5, see R6
	assign nxt_timer_control_b = wr_cb ? pwdata[7:0] :
		timer_control_b_ff; // see R6, see R8
	assign nxt_timer_irq_mask = wr_msk ?
		pwdata[fpt_pkg::IRQ_WIDTH-1:0] : timer_irq_mask_ff;
	assign nxt_pwm_pin_direction = wr_dir ? pwdata[1:0] :
		pwm_pin_direction_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_control_a_ff <= fpt_pkg::RESET_VALUE[7:0];
		else
			timer_control_a_ff <= nxt_timer_control_a;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_control_b_ff <= fpt_pkg::RESET_VALUE[7:0];
		else
			timer_control_b_ff <= nxt_timer_control_b;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_irq_mask_ff <= '0;
		else
			timer_irq_mask_ff <= nxt_timer_irq_mask;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pwm_pin_direction_ff <= '0;
		else
			pwm_pin_direction_ff <= nxt_pwm_pin_direction;
	end

	// ----------------------------------------------------------------
	// Counter register: a software write wins over the tick
	// ----------------------------------------------------------------
	assign nxt_count_load = wr_cnt ? pwdata[WIDTH-1:0] :
		(tick ? nxt_count : count_ff); // see R1, see R13

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_ff <= '0;
		else
			count_ff <= nxt_count_load;
	end

	// ----------------------------------------------------------------
	// Status and read data registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status_ff <= '0;
		else
			irq_status_ff <= nxt_status; // see R10
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= fpt_pkg::RESET_VALUE;
		else
			prdata_ff <= nxt_rdata;
	end

	// ----------------------------------------------------------------
	// Pins: drive only when direction is output and mode connects it
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_a_ff <= 1'b0;
		else
			pin_a_ff <= wave_a; // see R11
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_b_ff <= 1'b0;
		else
			pin_b_ff <= wave_b;
	end

	assign channel_a_output_pin  = pin_a_ff;
	assign channel_b_output_pin  = pin_b_ff;

	// ----------------------------------------------------------------
	// Pin enables: low while the pin is driven
	// ----------------------------------------------------------------
	wire drive_a = pwm_pin_direction_ff[0] &&
		(channel_a_output_mode != fpt_pkg::COM_DISCONNECT); // see R12
	wire drive_b = pwm_pin_direction_ff[1] &&
		(channel_b_output_mode != fpt_pkg::COM_DISCONNECT); // see R12
	assign channel_a_output_oe_n = !drive_a;
	assign channel_b_output_oe_n = !drive_b;
endmodule : fpt_timer

/* common/fpt_pkg.sv */
// Constants for the fast PWM timer channel: register map, fields, modes.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package fpt_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_A     = 8'h00;
	localparam logic [7:0] ADDR_CTRL_B     = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h08;
	localparam logic [7:0] ADDR_CMP_A      = 8'h0C;
	localparam logic [7:0] ADDR_CMP_B      = 8'h10;
	localparam logic [7:0] ADDR_COUNT      = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h1C;
	localparam logic [7:0] ADDR_PIN_DIR    = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_A_WGM_LSB  = 0;
	localparam int CTRL_A_COMB_LSB = 4;
	localparam int CTRL_A_COMA_LSB = 6;
	localparam int CTRL_B_CS_LSB   = 0;
	localparam int CTRL_B_WGM2_BIT = 3;
	localparam int IRQ_MATCH_A_BIT = 1;
	localparam int IRQ_MATCH_B_BIT = 2;
	localparam int IRQ_OVF_BIT     = 0;
	localparam int IRQ_WIDTH       = 3;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] WGM_NORMAL     = 3'h0;
	localparam logic [2:0] WGM_FAST_PWM8  = 3'h5;
	localparam logic [1:0] COM_DISCONNECT = 2'h0;
	localparam logic [1:0] COM_NONINVERT  = 2'h2;
	localparam logic [1:0] COM_INVERT     = 2'h3;
	localparam logic [15:0] TOP_PWM8      = 16'h00FF;
	localparam logic [15:0] TOP_FULL      = 16'hFFFF;
	localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;

	typedef enum logic [2:0]
	{
		CS_STOP     = 3'h0,
		CS_DIV1     = 3'h1,
		CS_DIV8     = 3'h2,
		CS_DIV64    = 3'h3,
		CS_DIV256   = 3'h4,
		CS_DIV1024  = 3'h5,
		CS_RSVD6    = 3'h6,
		CS_RSVD7    = 3'h7
	} fpt_clk_sel_type;

	localparam logic [9:0] DIV8_MASK    = 10'h007;
	localparam logic [9:0] DIV64_MASK   = 10'h03F;
	localparam logic [9:0] DIV256_MASK  = 10'h0FF;
	localparam logic [9:0] DIV1024_MASK = 10'h3FF;

endpackage : fpt_pkg

/* core/fpt_prescaler.sv */
// Prescaler: free-running divider, one-cycle counter tick per period.
// Assumes pclk is the system clock and sel comes from pclk logic.
`timescale 1ns/100ps
module fpt_prescaler
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [2:0] sel,
	output logic            tick
);
	logic [9:0] div_ff;
	logic [9:0] nxt_div;
	logic [9:0] mask;

	assign nxt_div = div_ff + 10'h001;

	// Tick when the low bits wrap; stop and reserved codes give no tick
	assign mask =
		(sel == fpt_pkg::CS_DIV8)    ? fpt_pkg::DIV8_MASK :
		(sel == fpt_pkg::CS_DIV64)   ? fpt_pkg::DIV64_MASK :
		(sel == fpt_pkg::CS_DIV256)  ? fpt_pkg::DIV256_MASK :
		fpt_pkg::DIV1024_MASK;

	assign tick = (sel == fpt_pkg::CS_DIV1) ? 1'b1 :
		((sel == fpt_pkg::CS_STOP) || (sel == fpt_pkg::CS_RSVD6) ||
		(sel == fpt_pkg::CS_RSVD7)) ? 1'b0 :
		((div_ff & mask) == mask); // see R8

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_ff <= 10'h000;
		else
			div_ff <= nxt_div;
	end
endmodule : fpt_prescaler

/* core/fpt_channel.sv */
// One compare channel: double-buffered compare value and output waveform.
// Assumes tick, count and top come from the shared counter on pclk.
`timescale 1ns/100ps
module fpt_channel
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             wr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic             tick,
	input  wire logic             at_top,
	input  wire logic             pwm_mode,
	input  wire logic [1:0]       mode,
	input  wire logic [WIDTH-1:0] count,
	output logic [WIDTH-1:0]      buf_val,
	output logic                  match,
	output logic                  wave
);
	logic [WIDTH-1:0] buf_ff;
	logic [WIDTH-1:0] act_ff;
	logic             wave_ff;
	logic             nxt_wave;

	assign buf_val = buf_ff;
	assign match   = tick && (count == act_ff); // see R3
	assign wave    = wave_ff;

	// ----------------------------------------------------------------
	// Waveform: set at bottom, clear at match; inverted form mirrors
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_wave = wave_ff;
		if (pwm_mode && tick)
		begin
			if (at_top)
				nxt_wave = (mode == fpt_pkg::COM_NONINVERT); // see R13
			else if (count == act_ff)
				nxt_wave = (mode == fpt_pkg::COM_INVERT); // see R11
		end
		else if (!pwm_mode && match && (mode != fpt_pkg::COM_DISCONNECT))
			nxt_wave = ~wave_ff; // see R4
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_ff  <= '0;
			act_ff  <= '0;
			wave_ff <= 1'b0;
		end
		else
		begin
			if (wr)
				buf_ff <= wdata; // see R14
			// Outside PWM the buffer passes straight through
			if (!pwm_mode || (tick && at_top))
				act_ff <= wr ? wdata : buf_ff; // see R14
			wave_ff <= nxt_wave;
		end
	end
endmodule : fpt_channel

/* sim/fpt_timer_asserts.sv */
// Port checker for the timer: bus errors, read data, irq mask, pin enables.
// Assumes it is bound to fpt_timer and sees only that module's ports.
`timescale 1ns/100ps
module fpt_timer_asserts
#(
	parameter int WIDTH = 16
)
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        channel_a_output_pin,
	input wire logic        channel_a_output_oe_n,
	input wire logic        channel_b_output_pin,
	input wire logic        channel_b_output_oe_n,
	input wire logic        irq
);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel & penable;
	wire wacc = psel & penable & pwrite;
	property p_unmap;
		acc && paddr > fpt_pkg::ADDR_PIN_DIR |-> pslverr;
	endproperty
	a_unmap: assert property (p_unmap) else $error("no error on hole");
	property p_rowr;
		wacc && paddr == fpt_pkg::ADDR_IRQ_STATUS |-> pslverr;
	endproperty
	a_rowr: assert property (p_rowr) else $error("status written");
	property p_wocl;
		acc && !pwrite && paddr == fpt_pkg::ADDR_IRQ_CLEAR |-> pslverr;
	endproperty
	a_wocl: assert property (p_wocl) else $error("clear was read");
	property p_idle;
		!psel |-> !pslverr && pready;
	endproperty
	a_idle: assert property (p_idle) else $error("idle bus answer");
	property p_rdz;
		wacc |=> prdata == 32'h0000_0000;
	endproperty
	a_rdz: assert property (p_rdz) else $error("data after write");
	property p_wide;
		prdata[31:16] == 16'h0000;
	endproperty
	a_wide: assert property (p_wide) else $error("upper bits set");
	property p_mask;
		wacc && paddr == fpt_pkg::ADDR_IRQ_MASK && pwdata[2:0] == 3'h0
			|=> !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
	property p_oe;
		$fell(channel_a_output_oe_n) |-> $past(wacc);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enabled alone");
	property p_dir;
		wacc && paddr == fpt_pkg::ADDR_PIN_DIR && !pwdata[1]
			|=> channel_b_output_oe_n;
	endproperty
	a_dir: assert property (p_dir) else $error("pin B still on");
endmodule : fpt_timer_asserts

bind fpt_timer fpt_timer_asserts #(.WIDTH(WIDTH)) u_chk
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq),
	.channel_a_output_pin(channel_a_output_pin),
	.channel_a_output_oe_n(channel_a_output_oe_n),
	.channel_b_output_pin(channel_b_output_pin),
	.channel_b_output_oe_n(channel_b_output_oe_n)
);

/* sim/fpt_load_model.sv */
// Lamp load on one output pin.
// Assumes oe_n low means driven; an undriven pad sits at its pull-down.
`timescale 1ns/100ps
module fpt_load_model
(
	input  wire logic pin,
	input  wire logic oe_n,
	output logic      lit
);
	// ----------------------------------------------------------------
	// Pad level
	// ----------------------------------------------------------------
	assign lit = oe_n ? 1'b0 : pin;
endmodule : fpt_load_model

/* sim/test_fast_pwm_timer_channel.sv */
// Self-checking bench: APB register access, duty, prescale, irq.
// Assumes fpt_timer with zero-wait APB; prdata stands in the access phase.
`timescale 1ns/100ps
module test_fast_pwm_timer_channel;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, c, v, rs, ha, hb;
	logic        pready, pslverr, pa, oa, pb, ob, irq, lit_a, lit_b;
	int          bad_count, cmp_count, n;
	fpt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .channel_a_output_pin(pa),
		.channel_a_output_oe_n(oa), .channel_b_output_pin(pb),
		.channel_b_output_oe_n(ob), .irq(irq));
	fpt_load_model u_lda (.pin(pa), .oe_n(oa), .lit(lit_a));
	fpt_load_model u_ldb (.pin(pb), .oe_n(ob), .lit(lit_b));
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xorshift();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : xorshift
	// High cycles per period, non-inverting or inverting
	function automatic logic [31:0] exp_high(logic [31:0] k, logic inv,
		logic [31:0] div);
		return inv ? (32'h0000_00FF - k) * div : (k + 32'h1) * div;
	endfunction : exp_high
	task automatic check(logic [31:0] s, logic [31:0] x, string m);
		cmp_count++;
		if (s !== x)
		begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : check
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
		int k;
		logic ok;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (k = 0; k < 50 && pready !== 1'b1; k++)
			@(posedge pclk);
		e = pslverr;
		q = prdata;
		ok = (pready === 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so later checks see what the write changed
		@(posedge pclk);
		if (!ok)
		begin
			bad_count++;
			print_verdict();
		end
	endtask : apb
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task automatic rd(logic [7:0] a, logic [31:0] x, string m);
		apb(a, 1'b0, 32'h0);
		check(q, x, m);
	endtask : rd
	// Lamp-on cycles over a window
	task automatic measure(int len);
		ha = 32'h0;
		hb = 32'h0;
		repeat (len) @(posedge pclk)
		begin
			ha += {31'h0, lit_a};
			hb += {31'h0, lit_b};
		end
	endtask : measure
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rs = 32'd11;
		bad_count = 0;
		cmp_count = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++)
			if (i != 7)
				rd(8'(i * 4), 32'h0, "reset value");
		apb(8'h24, 1'b0, 32'h0);
		check({31'h0, e}, 32'h1, "hole");
		apb(fpt_pkg::ADDR_IRQ_STATUS, 1'b1, 32'h7);
		check({31'h0, e}, 32'h1, "status write");
		apb(fpt_pkg::ADDR_IRQ_CLEAR, 1'b0, 32'h0);
		check({31'h0, e}, 32'h1, "clear read");
		$display("test registers done");
		wr(fpt_pkg::ADDR_PIN_DIR, 32'h3);
		wr(fpt_pkg::ADDR_CTRL_A, 32'hB1);
		// Divide by 1, 8 and 64; corner duties first
		for (int i = 0; i < 6; i++)
		begin
			n = i < 4 ? 1 : (i == 4 ? 8 : 64);
			wr(fpt_pkg::ADDR_CTRL_B, i < 4 ? 32'h9 : 32'h6 + i);
			c = i == 0 ? 32'h0 : (i == 1 ? 32'hFE : xorshift() % 255);
			wr(fpt_pkg::ADDR_CMP_A, c);
			wr(fpt_pkg::ADDR_CMP_B, 32'hFE - c);
			repeat (512 * n) @(posedge pclk);
			measure(256 * n);
			check(ha, exp_high(c, 1'b0, n), "duty A");
			check(hb, exp_high(32'hFE - c, 1'b1, n), "duty B");
		end
		$display("test waveform done");
		for (int i = 0; i < 3; i++)
		begin
			wr(fpt_pkg::ADDR_CTRL_B, i == 0 ? 32'h8 : 32'hD + i);
			apb(fpt_pkg::ADDR_COUNT, 1'b0, 32'h0);
			v = q;
			repeat (100) @(posedge pclk);
			rd(fpt_pkg::ADDR_COUNT, v, "stopped count");
		end
		wr(fpt_pkg::ADDR_IRQ_CLEAR, 32'h7);
		wr(fpt_pkg::ADDR_IRQ_MASK, 32'h2);
		check({31'h0, irq}, 32'h0, "irq idle");
		wr(fpt_pkg::ADDR_CTRL_B, 32'h9);
		repeat (300) @(posedge pclk);
		wr(fpt_pkg::ADDR_CTRL_B, 32'h8);
		rd(fpt_pkg::ADDR_IRQ_STATUS, 32'h7, "events");
		check({31'h0, irq}, 32'h1, "irq on");
		wr(fpt_pkg::ADDR_IRQ_MASK, 32'h0);
		check({31'h0, irq}, 32'h0, "irq masked");
		wr(fpt_pkg::ADDR_IRQ_MASK, 32'h2);
		wr(fpt_pkg::ADDR_IRQ_CLEAR, 32'h2);
		check({31'h0, irq}, 32'h0, "irq cleared");
		rd(fpt_pkg::ADDR_IRQ_STATUS, 32'h5, "after clear");
		$display("test irq done");
		wr(fpt_pkg::ADDR_PIN_DIR, 32'h0);
		wr(fpt_pkg::ADDR_CTRL_B, 32'h9);
		measure(256);
		check({30'h0, oa, ob}, 32'h3, "pins off");
		check(ha + hb, 32'h0, "lamp dark");
		$display("test direction done");
		print_verdict();
	end
endmodule : test_fast_pwm_timer_channel
